// file: embm_bus_master.sv
// Purpose: Master end of the external memory and peripheral bus.
// Assumes: Bus pins are synchronised in two stages; core side is on ref_clk.
// Notes:   Pin inputs reach the logic two cycles late, which shifts
//          acknowledge and read data by that much relative to the pins.
//
// How it works
// - Four phases pace every bus event
// - Address lines update entering phase zero
// - Idle cycles keep address lines unchanged
// - Read data taken at end of phase two
// - Write drivers on phase two, off phase zero
// - Data lines float without an access
// - Access strobe low during each access
// - Access strobe high under grant or reset
// - Space select high program, low data
// - Idle cycle drives space select high
// - Window select low for FF00 to FF7F data
// - Window select high for everything else
// - Window select changes only at phase zero
// - Write strobe low in phase one
// - Write strobe rises in phase three
// - Write strobe floats when not bus master
// - Read strobe low in phases one and two
// - Read/write line set at phase zero
// - Cycle ends two phases after acknowledge
// - Waits are larger of config and acknowledge
`timescale 1ns/100ps
module embm_bus_master (
    input  wire logic                              ref_clk,        // 100 MHz clock
    input  wire logic                              rst_n,          // Async reset, active low
    input  wire logic                              clk_en,         // Freezes all state when low
    input  wire logic                              req_valid,      // Core wants an access
    input  wire embm_pkg::embm_req_t               req,            // Access request
    input  wire logic [embm_pkg::WAIT_W-1:0]       bus_wait_cfg,   // Programmed wait states
    input  wire logic                              transfer_ack_n, // Pin, low ends the cycle
    input  wire logic                              bus_grant,      // Pin, bus given away
    input  wire logic [embm_pkg::DATA_W-1:0]       data_lines_in,  // Pin, data bus input
    output logic                                   req_taken,      // Pulse, request accepted
    output logic                                   rd_valid,       // Pulse, rd_data is new
    output logic [embm_pkg::DATA_W-1:0]            rd_data,        // Last read data
    output logic                                   access_done,    // Pulse, access finished
    output embm_pkg::embm_phase_t                  instr_phase,    // Current phase
    output embm_pkg::embm_pins_t                   bus_pins        // All bus pin drivers
);

    embm_pkg::embm_core_st_t q;
    embm_pkg::embm_core_st_t d;
    embm_pkg::embm_phase_t   phase;
    logic                    hold;

    // Peripheral window lives in data space only
    function automatic logic in_periph_window(input logic                        prog,
                                              input logic [embm_pkg::ADDR_W-1:0] addr);
        in_periph_window = (prog == embm_pkg::SPACE_DATA) &&
                           (addr >= embm_pkg::PERIPH_FIRST) &&
                           (addr <= embm_pkg::PERIPH_LAST);
    endfunction

    embm_phase_gen u_phase (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .hold    (hold),
        .phase_q (phase)
    );

    always_comb begin
        d             = q;
        hold          = 1'b0;
        d.req_taken   = embm_pkg::FLAG_CLR;
        d.rd_valid    = embm_pkg::FLAG_CLR;
        d.access_done = embm_pkg::FLAG_CLR;

        // Two-stage synchronisers for every pin input
        d.ack_s1 = transfer_ack_n;
        d.ack_s2 = q.ack_s1;
        d.gnt_s1 = bus_grant;
        d.gnt_s2 = q.gnt_s1;
        d.din_s1 = data_lines_in;
        d.din_s2 = q.din_s1;

        // Wait states: each one repeats phase one for two phases. The
        // acknowledge is looked at again after every wait, so the longer
        // of the two sources wins.
        if (q.state == embm_pkg::ST_ACCESS && phase == embm_pkg::PHASE_ONE) begin
            if (q.wait_half) begin
                hold        = 1'b1;
                d.wait_half = embm_pkg::FLAG_CLR;
                if (q.wait_cnt != embm_pkg::WAIT_NONE) begin
                    d.wait_cnt = q.wait_cnt - embm_pkg::WAIT_STEP;
                end
            end else if (q.wait_cnt != embm_pkg::WAIT_NONE ||
                         q.ack_s2 == embm_pkg::LVL_DEASSERT) begin
                hold        = 1'b1;
                d.wait_half = embm_pkg::FLAG_SET;
            end
        end

        // Pin value at the trailing edge of phase two reaches din_s2 one
        // edge later; it is taken here rather than lost to the sync delay.
        if (q.cap_pend) begin
            d.cap_pend = embm_pkg::FLAG_CLR;
            d.rd_data  = q.din_s2;
            d.rd_valid = embm_pkg::FLAG_SET;
        end

        // Everything below happens on the edge that leaves the phase
        if (!hold) begin
            case (phase)
                embm_pkg::PHASE_THREE: begin
                    // Entering phase zero: drivers off, next cycle decided
                    d.pins.data_oe_n = embm_pkg::OE_OFF;
                    if (q.state == embm_pkg::ST_ACCESS) begin
                        d.access_done = embm_pkg::FLAG_SET;
                        d.cap_pend    = !q.write;
                    end
                    if (q.gnt_s2 == embm_pkg::FLAG_CLR && req_valid) begin
                        d.state                          = embm_pkg::ST_ACCESS;
                        d.write                          = req.write;
                        d.wait_cnt                       = bus_wait_cfg;
                        d.wait_half                      = embm_pkg::FLAG_CLR;
                        d.req_taken                      = embm_pkg::FLAG_SET;
                        d.pins.address_lines             = req.addr;
                        d.pins.space_select              = req.program_space;
                        d.pins.peripheral_window_select_n =
                            in_periph_window(req.program_space, req.addr) ?
                            embm_pkg::LVL_ASSERT : embm_pkg::LVL_DEASSERT;
                        d.pins.read_write                = req.write ?
                            embm_pkg::RW_WRITE : embm_pkg::RW_READ;
                        d.pins.external_access_strobe_n  = embm_pkg::LVL_ASSERT;
                        d.pins.ctl_oe_n                  = embm_pkg::OE_ON;
                        d.pins.data_lines_out            = req.wdata;
                    end else begin
                        // Address is left alone on purpose to save toggling
                        d.state                          = embm_pkg::ST_IDLE;
                        d.pins.space_select              = embm_pkg::SPACE_PROGRAM;
                        d.pins.peripheral_window_select_n = embm_pkg::LVL_DEASSERT;
                        d.pins.read_write                = embm_pkg::RW_READ;
                        d.pins.external_access_strobe_n  = embm_pkg::LVL_DEASSERT;
                        d.pins.ctl_oe_n                  = q.gnt_s2 ?
                            embm_pkg::OE_OFF : embm_pkg::OE_ON;
                    end
                end
                embm_pkg::PHASE_ZERO: begin
                    // Entering phase one: the strobe of the access goes low
                    if (q.state == embm_pkg::ST_ACCESS) begin
                        if (q.write) begin
                            d.pins.write_strobe_n = embm_pkg::LVL_ASSERT;
                        end else begin
                            d.pins.read_strobe_n  = embm_pkg::LVL_ASSERT;
                        end
                    end
                end
                embm_pkg::PHASE_ONE: begin
                    // Entering phase two: write data onto the pins
                    if (q.state == embm_pkg::ST_ACCESS && q.write) begin
                        d.pins.data_oe_n = embm_pkg::OE_ON;
                    end
                end
                embm_pkg::PHASE_TWO: begin
                    // Entering phase three: memory latches on this rise
                    d.pins.write_strobe_n = embm_pkg::LVL_DEASSERT;
                    d.pins.read_strobe_n  = embm_pkg::LVL_DEASSERT;
                end
                default: begin
                    d.pins.data_oe_n = embm_pkg::OE_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q.state                           <= embm_pkg::ST_IDLE;
            q.wait_half                       <= embm_pkg::FLAG_CLR;
            q.wait_cnt                        <= embm_pkg::WAIT_NONE;
            q.write                           <= embm_pkg::FLAG_CLR;
            q.cap_pend                        <= embm_pkg::FLAG_CLR;
            q.ack_s1                          <= embm_pkg::LVL_DEASSERT;
            q.ack_s2                          <= embm_pkg::LVL_DEASSERT;
            q.gnt_s1                          <= embm_pkg::FLAG_CLR;
            q.gnt_s2                          <= embm_pkg::FLAG_CLR;
            q.din_s1                          <= embm_pkg::DATA_RESET;
            q.din_s2                          <= embm_pkg::DATA_RESET;
            q.pins.address_lines              <= embm_pkg::ADDR_RESET;
            q.pins.space_select               <= embm_pkg::SPACE_PROGRAM;
            q.pins.peripheral_window_select_n <= embm_pkg::LVL_DEASSERT;
            q.pins.external_access_strobe_n   <= embm_pkg::LVL_DEASSERT;
            q.pins.read_strobe_n              <= embm_pkg::LVL_DEASSERT;
            q.pins.write_strobe_n             <= embm_pkg::LVL_DEASSERT;
            q.pins.read_write                 <= embm_pkg::RW_READ;
            q.pins.ctl_oe_n                   <= embm_pkg::OE_OFF;
            q.pins.data_lines_out             <= embm_pkg::DATA_RESET;
            q.pins.data_oe_n                  <= embm_pkg::OE_OFF;
            q.req_taken                       <= embm_pkg::FLAG_CLR;
            q.rd_valid                        <= embm_pkg::FLAG_CLR;
            q.rd_data                         <= embm_pkg::DATA_RESET;
            q.access_done                     <= embm_pkg::FLAG_CLR;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign req_taken   = q.req_taken;
    assign rd_valid    = q.rd_valid;
    assign rd_data     = q.rd_data;
    assign access_done = q.access_done;
    assign instr_phase = phase;
    assign bus_pins    = q.pins;

    // Checks and coverage
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic [3:0] access_len;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_len <= 4'h0;
        end else if (clk_en) begin
            if (d.req_taken) begin
                access_len <= 4'h1;
            end else if (q.state == embm_pkg::ST_ACCESS && access_len != 4'hf) begin
                access_len <= access_len + 4'h1;
            end
        end
    end

    a_addr_phase_zero: assert property (
        $changed(q.pins.address_lines) |-> phase == embm_pkg::PHASE_ZERO && q.req_taken)
        else $error("address lines moved outside phase zero entry");

    a_idle_addr_held: assert property (
        (phase == embm_pkg::PHASE_ZERO && $past(phase) == embm_pkg::PHASE_THREE &&
         !q.req_taken) |-> $stable(q.pins.address_lines) && q.pins.space_select)
        else $error("idle cycle changed address or left space select low");

    a_data_float_idle: assert property (
        q.pins.external_access_strobe_n |-> q.pins.data_oe_n)
        else $error("data lines driven without an access");

    a_data_oe_phase: assert property (
        $fell(q.pins.data_oe_n) |-> phase == embm_pkg::PHASE_TWO && q.write
        ##2 phase == embm_pkg::PHASE_ZERO && q.pins.data_oe_n)
        else $error("write drivers not on phase two through phase three");

    a_write_strobe_win: assert property (
        $fell(q.pins.write_strobe_n) |->
        phase == embm_pkg::PHASE_ONE && q.pins.read_write == embm_pkg::RW_WRITE)
        else $error("write strobe fell outside phase one");

    a_strobe_rise_three: assert property (
        ($rose(q.pins.write_strobe_n) || $rose(q.pins.read_strobe_n)) |->
        phase == embm_pkg::PHASE_THREE)
        else $error("read or write strobe rose outside phase three");

    a_read_strobe_dir: assert property (
        !q.pins.read_strobe_n |-> q.pins.read_write == embm_pkg::RW_READ &&
        q.pins.write_strobe_n && phase inside {embm_pkg::PHASE_ONE, embm_pkg::PHASE_TWO})
        else $error("read strobe low with wrong direction or phase");

    a_grant_strobe_high: assert property (
        (phase == embm_pkg::PHASE_ZERO && $past(phase) == embm_pkg::PHASE_THREE &&
         $past(q.gnt_s2)) |-> q.pins.external_access_strobe_n && q.pins.ctl_oe_n)
        else $error("bus used or strobe low while granted away");

    a_periph_window: assert property (
        !q.pins.peripheral_window_select_n |->
        q.pins.space_select == embm_pkg::SPACE_DATA &&
        q.pins.address_lines >= embm_pkg::PERIPH_FIRST &&
        q.pins.address_lines <= embm_pkg::PERIPH_LAST)
        else $error("window select low outside peripheral range");

    a_window_phase_zero: assert property (
        $changed(q.pins.peripheral_window_select_n) |-> phase == embm_pkg::PHASE_ZERO)
        else $error("window select changed outside phase zero");

    a_no_wait_length: assert property (
        (q.req_taken && q.wait_cnt == embm_pkg::WAIT_NONE && !q.ack_s1 && !q.ack_s2 &&
         !transfer_ack_n && clk_en) ##1 clk_en [*3] |=> q.access_done || q.req_taken)
        else $error("unwaited access did not take four phases");

    // Phase one is left exactly when both wait sources are used up
    a_wait_bound: assert property (
        q.state == embm_pkg::ST_ACCESS && phase == embm_pkg::PHASE_ONE &&
        !q.wait_half && clk_en |=>
        (phase == embm_pkg::PHASE_TWO) ==
        ($past(q.wait_cnt) == embm_pkg::WAIT_NONE && $past(q.ack_s2) == embm_pkg::LVL_ASSERT))
        else $error("phase one not left when waits ran out");

    c_read_access:  cover property (q.req_taken && !q.write ##[1:40] q.rd_valid);
    c_write_access: cover property (q.req_taken && q.write ##[1:40] q.access_done);
    c_wait_state:   cover property (q.state == embm_pkg::ST_ACCESS && access_len == 4'h8);
    c_periph_hit:   cover property (!q.pins.peripheral_window_select_n);
    c_grant_away:   cover property (q.gnt_s2 && q.pins.ctl_oe_n);

endmodule

// file: embm_mem_model.sv
// Purpose: Static memory with acknowledge on the far side of the bus.
// Assumes: Sixteen words, picked by the low address bits.
// Notes:   Undriven data lines toggle every cycle, so a stale sample never matches.
`timescale 1ns/100ps
module embm_mem_model (
    input  wire logic                 ref_clk, // Clock
    input  wire embm_pkg::embm_pins_t pins,    // Bus pins from the master
    input  wire logic [15:0]          dbus,    // Resolved data lines
    input  wire logic [3:0]           slow,    // Acknowledge delay in cycles
    output logic [15:0]               drive,   // Data offered by the memory
    output logic                      ack_n    // Transfer acknowledge
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [3:0]  cnt  = 4'h0;
    logic        wr_q = 1'b1;
    logic        rd;
    assign rd = !pins.read_strobe_n && !pins.ctl_oe_n;
    assign drive = rd ? mem[pins.address_lines[3:0]] : ~last;
    assign ack_n = (cnt != 4'h0);
    always_ff @(posedge ref_clk) begin
        wr_q <= pins.write_strobe_n;
        last <= drive;
        if (!wr_q && pins.write_strobe_n) begin
            mem[pins.address_lines[3:0]] <= dbus;
        end
        if (pins.external_access_strobe_n) begin
            cnt <= slow;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// file: embm_phase_gen.sv
// Purpose: Four-phase instruction clock counter.
// Assumes: hold is only raised by the bus master while in phase one.
// Notes:   A held phase one is how wait states stretch the bus cycle.
`timescale 1ns/100ps
module embm_phase_gen (
    input  wire logic                 ref_clk, // Core clock, one phase per cycle
    input  wire logic                 rst_n,   // Asynchronous reset, active low
    input  wire logic                 clk_en,  // Freezes the counter while low
    input  wire logic                 hold,    // Stay in phase one this cycle
    output embm_pkg::embm_phase_t     phase_q  // Current phase
);

    embm_pkg::embm_phase_st_t q;
    embm_pkg::embm_phase_st_t d;

    always_comb begin
        d = q;
        if (!(hold && q.phase == embm_pkg::PHASE_ONE)) begin
            d.phase = embm_pkg::embm_phase_t'(q.phase + embm_pkg::PHASE_STEP);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q.phase <= embm_pkg::PHASE_ZERO;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign phase_q = q.phase;

endmodule

// file: embm_pkg.sv
// Purpose: Shared types and constants of the external memory bus master.
// Assumes: One ref_clk cycle is one instruction-clock phase.
// Notes:   Pin levels are named so that the logic never shows a bare 1 or 0.
package embm_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 4;

    // Peripheral window in data space
    localparam logic [ADDR_W-1:0] PERIPH_FIRST = 16'hff00;
    localparam logic [ADDR_W-1:0] PERIPH_LAST  = 16'hff7f;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [WAIT_W-1:0] WAIT_NONE  = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_STEP  = 4'h1;

    localparam logic LVL_ASSERT    = 1'b0;
    localparam logic LVL_DEASSERT  = 1'b1;
    localparam logic SPACE_PROGRAM = 1'b1;
    localparam logic SPACE_DATA    = 1'b0;
    localparam logic RW_READ       = 1'b1;
    localparam logic RW_WRITE      = 1'b0;
    localparam logic OE_ON         = 1'b0;
    localparam logic OE_OFF        = 1'b1;
    localparam logic FLAG_SET      = 1'b1;
    localparam logic FLAG_CLR      = 1'b0;

    localparam logic [1:0] PHASE_STEP = 2'h1;

    typedef enum logic [1:0] {
        PHASE_ZERO,
        PHASE_ONE,
        PHASE_TWO,
        PHASE_THREE
    } embm_phase_t;

    typedef enum logic {
        ST_IDLE,
        ST_ACCESS
    } embm_state_t;

    // One access request from the core
    typedef struct packed {
        logic              write;         // 1 write, 0 read
        logic              program_space; // 1 program, 0 data
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } embm_req_t;

    // Everything that leaves the chip on the bus pins
    typedef struct packed {
        logic [ADDR_W-1:0] address_lines;
        logic              space_select;
        logic              peripheral_window_select_n;
        logic              external_access_strobe_n;
        logic              read_strobe_n;
        logic              write_strobe_n;
        logic              read_write;
        logic              ctl_oe_n;      // Address, selects, rw and strobes
        logic [DATA_W-1:0] data_lines_out;
        logic              data_oe_n;
    } embm_pins_t;

    typedef struct packed {
        embm_phase_t phase;
    } embm_phase_st_t;

    typedef struct packed {
        embm_state_t       state;
        logic              wait_half;
        logic [WAIT_W-1:0] wait_cnt;
        logic              write;
        logic              cap_pend;
        logic              ack_s1;
        logic              ack_s2;
        logic              gnt_s1;
        logic              gnt_s2;
        logic [DATA_W-1:0] din_s1;
        logic [DATA_W-1:0] din_s2;
        embm_pins_t        pins;
        logic              req_taken;
        logic              rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic              access_done;
    } embm_core_st_t;

endpackage

// file: external_memory_bus_master_bench.sv
// Purpose: Self-checking bench of the bus master against the memory model.
// Assumes: clk_en tied high; requests held until taken, except the one withdrawn untaken under grant.
// Notes:   Acknowledge waits include the two-cycle pin synchroniser delay.
`timescale 1ns/100ps
module external_memory_bus_master_bench;
    logic                  ref_clk   = 1'b0;
    logic                  rst_n     = 1'b0;
    logic                  req_valid = 1'b0;
    embm_pkg::embm_req_t   req       = '0;
    logic [3:0]            cfg       = 4'h0;
    logic [3:0]            slow      = 4'h0;
    logic                  bus_grant = 1'b0;
    logic                  ack_n;
    logic                  req_taken;
    logic                  rd_valid;
    logic                  access_done;
    logic [15:0]           rd_data;
    logic [15:0]           drive;
    logic [15:0]           dbus;
    embm_pkg::embm_phase_t phase;
    embm_pkg::embm_pins_t  pins;
    int                    mismatches  = 0;
    int                    comparisons = 0;
    int                    cycles      = 0;
    int                    len;
    assign dbus = (pins.data_oe_n == embm_pkg::OE_ON) ? pins.data_lines_out : drive;
    embm_bus_master dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .req_valid(req_valid), .req(req), .bus_wait_cfg(cfg), .transfer_ack_n(ack_n),
        .bus_grant(bus_grant), .data_lines_in(dbus), .req_taken(req_taken),
        .rd_valid(rd_valid), .rd_data(rd_data), .access_done(access_done),
        .instr_phase(phase), .bus_pins(pins));
    embm_mem_model mem (.ref_clk(ref_clk), .pins(pins), .dbus(dbus), .slow(slow),
        .drive(drive), .ack_n(ack_n));
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp1(string name, logic exp, logic got);
        cmp(name, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One access; pins checked phase by phase, length left in len
    task automatic access(logic w, logic ps, logic [15:0] a, logic [15:0] d);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = '{w, ps, a, d};
        len = 0;
        while (req_taken !== 1'b1 && len < 40) begin
            @(negedge ref_clk);
            len++;
        end
        req_valid = 1'b0;
        cmp1("request taken", 1'b1, req_taken);
        cmp("address", a, pins.address_lines);
        cmp1("space", ps, pins.space_select);
        cmp1("window", !(ps == embm_pkg::SPACE_DATA && a >= embm_pkg::PERIPH_FIRST
            && a <= embm_pkg::PERIPH_LAST), pins.peripheral_window_select_n);
        cmp1("direction", !w, pins.read_write);
        cmp1("access strobe", 1'b0, pins.external_access_strobe_n);
        len = 0;
        while (access_done !== 1'b1 && len < 40) begin
            @(negedge ref_clk);
            len++;
            if (phase == embm_pkg::PHASE_ONE) begin
                cmp1("strobe", 1'b0, w ? pins.write_strobe_n : pins.read_strobe_n);
            end
            if (phase == embm_pkg::PHASE_THREE) begin
                cmp1("strobe", 1'b1, w ? pins.write_strobe_n : pins.read_strobe_n);
            end
            if (phase == embm_pkg::PHASE_TWO && w) begin
                cmp("write data", d, dbus);
            end
        end
        cmp1("access done", 1'b1, access_done);
        cmp1("data release", 1'b1, pins.data_oe_n);
        if (!w) begin
            @(negedge ref_clk);
            cmp1("read valid", 1'b1, rd_valid);
            cmp("read data", d, rd_data);
        end
    endtask
    task automatic t_plain();
        access(1'b1, 1'b0, 16'hff7f, 16'h1234);
        access(1'b1, 1'b0, 16'hff80, 16'h4321);
        access(1'b1, 1'b1, 16'hff00, 16'h0f0f);
        access(1'b1, 1'b0, 16'hff10, 16'ha5c3);
        cmp("write length", 16'h0004, len[15:0]);
        access(1'b0, 1'b0, 16'hff10, 16'ha5c3);
        cmp("read length", 16'h0004, len[15:0]);
    endtask
    task automatic t_waits();
        cfg = 4'h2;
        slow = 4'h1;
        access(1'b0, 1'b0, 16'hff10, 16'ha5c3);
        cmp("config waits", 16'h0008, len[15:0]);
        cfg = 4'h0;
        slow = 4'h6;
        access(1'b0, 1'b0, 16'hff7f, 16'h1234);
        cmp("ack waits", 16'h000c, len[15:0]);
        slow = 4'h0;
    endtask
    task automatic t_idle();
        repeat (8) @(negedge ref_clk);
        cmp("held address", 16'hff7f, pins.address_lines);
        cmp1("idle space", 1'b1, pins.space_select);
        cmp1("idle data", 1'b1, pins.data_oe_n);
    endtask
    task automatic t_grant();
        logic seen;
        seen = 1'b0;
        bus_grant = 1'b1;
        repeat (12) @(negedge ref_clk);
        req_valid = 1'b1;
        req = '{1'b1, 1'b0, 16'h0003, 16'h0055};
        repeat (12) begin
            @(negedge ref_clk);
            seen = seen | req_taken;
        end
        cmp1("taken under grant", 1'b0, seen);
        cmp1("float under grant", 1'b1, pins.ctl_oe_n);
        cmp1("strobe under grant", 1'b1, pins.external_access_strobe_n);
        req_valid = 1'b0;
        bus_grant = 1'b0;
        access(1'b0, 1'b0, 16'hff10, 16'ha5c3);
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        cmp1("reset data", 1'b1, pins.data_oe_n);
        cmp1("reset strobe", 1'b1, pins.external_access_strobe_n);
        @(negedge ref_clk);
        rst_n = 1'b1;
        t_plain();
        t_waits();
        t_idle();
        t_grant();
        stop_test();
    end
endmodule
